// ---- design/lpm_pkg.sv ----
// Purpose: constants and types shared by the low-power mode controller
// Assumes: 100 MHz system clock, two cores, four wake pins
// Notes: register map is word aligned on an AXI4-Lite slave
//
// Overview of operation
// - any reset enters reset state, starts main oscillator, then goes active
// - external reset pin forces reset state from every power mode
// - all cores waiting without deep select enters sleep, core clocks gated
// - sleep-on-exit core re-sleeps on leaving its handler
// - wake-on-pending core wakes on any pending interrupt, enabled or not
// - deep request while not ready sleeps first, deepens once ready
// - connected debugger holds a deep request in sleep until disconnect
// - deep sleep stops fast clocks, freezes io, retains, swaps regulators
// - freeze and hibernate bits act only with unlock key 0x3a
// - hibernate wake uses pin polarity, pin mask and alarm mask fields
// - freeze bit freezes io; hibernate bit plus wait on all cores hibernates
// - hibernate stops all clocks, retains, powers regulators down, freezes io
// - enabled interrupt in sleep returns to active
// - enabled interrupt in deep sleep restores active configuration
// - debug wake from deep sleep restores clocks but cores stay asleep
// - hibernate wake ramps regulators, resets logic, starts oscillator, runs
// - deep sleep keeps slow clock and low-power wake sources alive
// - rtc alarm wakes the device from sleep and deep sleep, and from hibernate only with the alarm mask bit set
package lpm_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_SEQ_NS = 1000;
	localparam int RAMP_NS = 2000;
	localparam logic [7:0] RESET_CYCLES = 8'((RESET_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] RAMP_CYCLES = 8'((RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// sizes
	localparam int NUM_CORES = 2;
	localparam int NUM_WAKE_PINS = 4;
	localparam int ADDR_W = 8;
	// register byte addresses
	localparam logic [7:0] PWR_CTRL_ADDR = 8'h00;
	localparam logic [7:0] HIB_CTRL_ADDR = 8'h04;
	localparam logic [7:0] HIB_SCRATCH_ADDR = 8'h08;
	// power_control fields
	localparam int MODE_LSB = 0;
	localparam int LP_READY_BIT = 5;
	// hibernate_control fields
	localparam int TOKEN_LSB = 0;
	localparam int UNLOCK_LSB = 8;
	localparam int FREEZE_BIT = 17;
	localparam int ALARM_MASK_BIT = 18;
	localparam int POL_LSB = 20;
	localparam int PIN_MASK_LSB = 24;
	localparam int HIB_BIT = 31;
	localparam logic [7:0] UNLOCK_KEY = 8'h3a;
	localparam logic [31:0] HIB_CTRL_WMASK = 32'h8ff6_ffff;
	// reset values
	localparam logic [31:0] HIB_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		M_RESET = 3'h1,
		M_ACTIVE = 3'h2,
		M_SLEEP = 3'h3,
		M_DEEP = 3'h4,
		M_HIB = 3'h5,
		M_HIB_WAKE = 3'h6
	} pmode_t;
endpackage

// ---- design/hib_wake_if.sv ----
`timescale 1ns/100ps
// Purpose: carries hibernate wake inputs and configuration to the evaluator
// Assumes: one system clock
// Notes: listen is high only while the controller sits in hibernate
interface hib_wake_if;
	logic [3:0] pins;
	logic [3:0] polarity;
	logic [3:0] mask;
	logic alarm;
	logic alarm_mask;
	logic listen;
	logic wake;
	modport ctrl(output pins, output polarity, output mask, output alarm, output alarm_mask, output listen,
		input wake);
	modport eval(input pins, input polarity, input mask, input alarm, input alarm_mask, input listen,
		output wake);
endinterface

// ---- design/hib_wake_eval.sv ----
`timescale 1ns/100ps
// Purpose: decides a hibernate wake from pins and rtc alarm
// Assumes: pins already synchronous to the clock
// Notes: wake is registered, so the controller reacts one cycle later
module hib_wake_eval (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// wake sources and configuration
	hib_wake_if.eval wk
);
	typedef struct packed {
		logic wake;
	} ev_t;
	ev_t st_q;
	ev_t st_d;
	logic pin_hit;
	assign pin_hit = |(~(wk.pins ^ wk.polarity) & wk.mask);
	always_comb begin
		st_d = st_q;
		st_d.wake = wk.listen & (pin_hit | (wk.alarm & wk.alarm_mask));
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign wk.wake = st_q.wake;
	a_pin_wake_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(wk.listen && (|(~(wk.pins ^ wk.polarity) & wk.mask))) |=> wk.wake) else $error("masked pin wake missed");
endmodule // hib_wake_eval

// ---- design/lpm_ctrl.sv ----
`timescale 1ns/100ps
// Purpose: power mode sequencer with AXI4-Lite register slave
// Assumes: core strobes and interrupt levels synchronous to CLK_I
// Notes: core system-control bits arrive as levels from the cores themselves
module lpm_ctrl (
	// clock and power-on reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// AXI4-Lite write address and data
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	// AXI4-Lite read
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// core requests
	input wire logic [1:0] CORE_DEEP_SLEEP_SELECT_I,
	input wire logic [1:0] CORE_SLEEP_ON_ISR_EXIT_I,
	input wire logic [1:0] CORE_WAKE_ON_PENDING_I,
	input wire logic [1:0] CORE_WAIT_I,
	input wire logic [1:0] CORE_ISR_EXIT_I,
	input wire logic [1:0] IRQ_ENABLED_I,
	input wire logic [1:0] IRQ_PENDING_I,
	// resets, debug, wake sources
	input wire logic EXT_RESET_N_I,
	input wire logic INT_RESET_I,
	input wire logic LOW_POWER_READY_I,
	input wire logic DEBUG_CONNECTED_I,
	input wire logic DEBUG_WAKE_I,
	input wire logic [3:0] WAKE_PIN_I,
	input wire logic RTC_ALARM_I,
	// power controls
	output logic [1:0] CORE_CLK_EN_O,
	output logic HF_CLK_EN_O,
	output logic LF_CLK_EN_O,
	output logic MAIN_OSC_EN_O,
	output logic IO_FREEZE_O,
	output logic RETENTION_EN_O,
	output logic NONRET_RESET_O,
	output logic ACTIVE_REG_EN_O,
	output logic DEEP_REG_EN_O,
	output logic SYS_RESET_O,
	output logic [2:0] POWER_MODE_O
);
	typedef struct packed {
		lpm_pkg::pmode_t mode;
		logic [7:0] cnt;
		logic [1:0] core_sleep;
		logic ds_pend;
		logic [31:0] hib_ctl;
		logic [31:0] scratch;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ctl_t;
	ctl_t st_q;
	ctl_t st_d;
	logic [1:0] wake_v;
	logic quiet;
	logic unlocked;
	logic all_asleep;
	logic want_deep;
	logic deep_ok;
	hib_wake_if wk();

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] word_addr(input logic [7:0] a);
		return {a[7:2], 2'h0};
	endfunction

	assign unlocked = st_q.hib_ctl[lpm_pkg::UNLOCK_LSB +: 8] == lpm_pkg::UNLOCK_KEY;
	assign quiet = EXT_RESET_N_I && !INT_RESET_I;
	assign wake_v = IRQ_ENABLED_I | (CORE_WAKE_ON_PENDING_I & IRQ_PENDING_I) | {1'b0, RTC_ALARM_I};
	assign all_asleep = &st_q.core_sleep;
	assign want_deep = &CORE_DEEP_SLEEP_SELECT_I;
	// debugger and ready both gate deep entry
	assign deep_ok = LOW_POWER_READY_I && !DEBUG_CONNECTED_I;

	// hibernate wake evaluator
	assign wk.pins = WAKE_PIN_I;
	assign wk.polarity = st_q.hib_ctl[lpm_pkg::POL_LSB +: 4];
	assign wk.mask = st_q.hib_ctl[lpm_pkg::PIN_MASK_LSB +: 4];
	assign wk.alarm = RTC_ALARM_I;
	assign wk.alarm_mask = st_q.hib_ctl[lpm_pkg::ALARM_MASK_BIT];
	assign wk.listen = st_q.mode == lpm_pkg::M_HIB;
	hib_wake_eval u_wake (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.wk(wk)
	);

	always_comb begin
		st_d = st_q;
		// bus: take address and data independently
		if (S_AXI_AWVALID_I && !st_q.aw_have) begin
			st_d.aw_have = 1'b1;
			st_d.aw_addr = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && !st_q.w_have) begin
			st_d.w_have = 1'b1;
			st_d.w_data = S_AXI_WDATA_I;
			st_d.w_strb = S_AXI_WSTRB_I;
		end
		if (st_q.bvalid && S_AXI_BREADY_I) begin
			st_d.bvalid = 1'b0;
		end
		if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
			st_d.aw_have = 1'b0;
			st_d.w_have = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = lpm_pkg::RESP_OKAY;
			case (word_addr(st_q.aw_addr))
				lpm_pkg::PWR_CTRL_ADDR: begin
					// read-only status, write ignored
				end
				lpm_pkg::HIB_CTRL_ADDR: begin
					st_d.hib_ctl = apply_strb(st_q.hib_ctl, st_q.w_data, st_q.w_strb) & lpm_pkg::HIB_CTRL_WMASK;
				end
				lpm_pkg::HIB_SCRATCH_ADDR: begin
					st_d.scratch = apply_strb(st_q.scratch, st_q.w_data, st_q.w_strb);
				end
				default: begin
					st_d.bresp = lpm_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (st_q.rvalid && S_AXI_RREADY_I) begin
			st_d.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID_I && !st_q.rvalid) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = lpm_pkg::RESP_OKAY;
			case (word_addr(S_AXI_ARADDR_I))
				lpm_pkg::PWR_CTRL_ADDR: begin
					st_d.rdata = {26'h0, LOW_POWER_READY_I, 2'h0, st_q.mode};
				end
				lpm_pkg::HIB_CTRL_ADDR: begin
					st_d.rdata = st_q.hib_ctl;
				end
				lpm_pkg::HIB_SCRATCH_ADDR: begin
					st_d.rdata = st_q.scratch;
				end
				default: begin
					st_d.rdata = 32'h0000_0000;
					st_d.rresp = lpm_pkg::RESP_SLVERR;
				end
			endcase
		end
		// per-core sleep tracking
		if (st_q.mode == lpm_pkg::M_ACTIVE || st_q.mode == lpm_pkg::M_SLEEP || st_q.mode == lpm_pkg::M_DEEP) begin
			st_d.core_sleep = (st_q.core_sleep & ~wake_v) | CORE_WAIT_I | (CORE_ISR_EXIT_I & CORE_SLEEP_ON_ISR_EXIT_I);
		end
		case (st_q.mode)
			lpm_pkg::M_RESET: begin
				st_d.core_sleep = 2'h0;
				st_d.cnt = st_q.cnt - 8'h01;
				if (st_q.cnt <= 8'h01) begin
					st_d.mode = lpm_pkg::M_ACTIVE;
				end
			end
			lpm_pkg::M_ACTIVE: begin
				if (all_asleep && !(|wake_v)) begin
					if (st_q.hib_ctl[lpm_pkg::HIB_BIT] && unlocked) begin
						st_d.mode = lpm_pkg::M_HIB;
					end else if (want_deep && deep_ok) begin
						st_d.mode = lpm_pkg::M_DEEP;
					end else begin
						st_d.mode = lpm_pkg::M_SLEEP;
						st_d.ds_pend = want_deep;
					end
				end
			end
			lpm_pkg::M_SLEEP: begin
				if (|wake_v) begin
					st_d.mode = lpm_pkg::M_ACTIVE;
					st_d.ds_pend = 1'b0;
				end else if (st_q.ds_pend && deep_ok) begin
					st_d.mode = lpm_pkg::M_DEEP;
				end
			end
			lpm_pkg::M_DEEP: begin
				if (|wake_v) begin
					st_d.mode = lpm_pkg::M_ACTIVE;
					st_d.ds_pend = 1'b0;
				end else if (DEBUG_WAKE_I) begin
					st_d.mode = lpm_pkg::M_SLEEP;
				end
			end
			lpm_pkg::M_HIB: begin
				if (wk.wake) begin
					st_d.mode = lpm_pkg::M_HIB_WAKE;
					st_d.cnt = lpm_pkg::RAMP_CYCLES;
					st_d.hib_ctl[lpm_pkg::HIB_BIT] = 1'b0;
				end
			end
			lpm_pkg::M_HIB_WAKE: begin
				st_d.cnt = st_q.cnt - 8'h01;
				if (st_q.cnt <= 8'h01) begin
					st_d.mode = lpm_pkg::M_RESET;
					st_d.cnt = lpm_pkg::RESET_CYCLES;
				end
			end
			default: begin
				st_d.mode = lpm_pkg::M_RESET;
				st_d.cnt = lpm_pkg::RESET_CYCLES;
			end
		endcase
		// external or internal reset overrides every mode
		if (!quiet) begin
			st_d.mode = lpm_pkg::M_RESET;
			st_d.cnt = lpm_pkg::RESET_CYCLES;
			st_d.core_sleep = 2'h0;
			st_d.ds_pend = 1'b0;
		end
	end

	// token and scratch cleared only by power-on reset
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			st_q <= '0;
			st_q.mode <= lpm_pkg::M_RESET;
			st_q.cnt <= lpm_pkg::RESET_CYCLES;
			st_q.hib_ctl <= lpm_pkg::HIB_CTRL_RESET;
			st_q.scratch <= lpm_pkg::SCRATCH_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign S_AXI_AWREADY_O = !st_q.aw_have;
	assign S_AXI_WREADY_O = !st_q.w_have;
	assign S_AXI_BVALID_O = st_q.bvalid;
	assign S_AXI_BRESP_O = st_q.bresp;
	assign S_AXI_ARREADY_O = !st_q.rvalid;
	assign S_AXI_RVALID_O = st_q.rvalid;
	assign S_AXI_RDATA_O = st_q.rdata;
	assign S_AXI_RRESP_O = st_q.rresp;

	// core clocks run only in active for awake cores
	assign CORE_CLK_EN_O = (st_q.mode == lpm_pkg::M_ACTIVE) ? ~st_q.core_sleep : 2'h0;
	assign HF_CLK_EN_O = st_q.mode == lpm_pkg::M_RESET || st_q.mode == lpm_pkg::M_ACTIVE
		|| st_q.mode == lpm_pkg::M_SLEEP;
	// slow clock stops only in hibernate and its ramp
	assign LF_CLK_EN_O = !(st_q.mode == lpm_pkg::M_HIB || st_q.mode == lpm_pkg::M_HIB_WAKE);
	assign MAIN_OSC_EN_O = HF_CLK_EN_O;
	// freeze bit takes effect when unlocked
	assign IO_FREEZE_O = (st_q.hib_ctl[lpm_pkg::FREEZE_BIT] && unlocked) || st_q.mode == lpm_pkg::M_DEEP
		|| st_q.mode == lpm_pkg::M_HIB || st_q.mode == lpm_pkg::M_HIB_WAKE;
	assign RETENTION_EN_O = st_q.mode == lpm_pkg::M_DEEP || st_q.mode == lpm_pkg::M_HIB;
	assign NONRET_RESET_O = !(st_q.mode == lpm_pkg::M_ACTIVE || st_q.mode == lpm_pkg::M_SLEEP);
	assign ACTIVE_REG_EN_O = st_q.mode == lpm_pkg::M_RESET || st_q.mode == lpm_pkg::M_ACTIVE
		|| st_q.mode == lpm_pkg::M_SLEEP || st_q.mode == lpm_pkg::M_HIB_WAKE;
	assign DEEP_REG_EN_O = st_q.mode == lpm_pkg::M_DEEP || st_q.mode == lpm_pkg::M_HIB_WAKE;
	assign SYS_RESET_O = st_q.mode == lpm_pkg::M_RESET || st_q.mode == lpm_pkg::M_HIB_WAKE;
	assign POWER_MODE_O = st_q.mode;

	a_reset_to_active: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q.mode == lpm_pkg::M_RESET && st_q.cnt == 8'h01 && quiet) |=> (st_q.mode == lpm_pkg::M_ACTIVE
		&& !SYS_RESET_O && MAIN_OSC_EN_O)) else $error("reset sequence did not reach active");
	a_ext_reset_forces: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		!EXT_RESET_N_I |=> (st_q.mode == lpm_pkg::M_RESET && SYS_RESET_O)) else $error("external reset ignored");
	a_sleep_entry_gate: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q.mode == lpm_pkg::M_ACTIVE && all_asleep && !(|wake_v) && quiet && !want_deep
		&& !(st_q.hib_ctl[lpm_pkg::HIB_BIT] && unlocked)) |=> (st_q.mode == lpm_pkg::M_SLEEP
		&& CORE_CLK_EN_O == 2'h0)) else $error("sleep entry missed");
	a_pending_wakes: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q.mode == lpm_pkg::M_SLEEP && CORE_WAKE_ON_PENDING_I[0] && IRQ_PENDING_I[0] && quiet
		&& !CORE_WAIT_I[0] && !CORE_ISR_EXIT_I[0])
		|=> (st_q.mode == lpm_pkg::M_ACTIVE && CORE_CLK_EN_O[0])) else $error("pending did not wake core");
	a_exit_resleeps: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q.mode == lpm_pkg::M_ACTIVE && CORE_ISR_EXIT_I[0] && CORE_SLEEP_ON_ISR_EXIT_I[0] && quiet)
		|=> !CORE_CLK_EN_O[0]) else $error("core resumed after handler exit");
	a_deep_needs_ready: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q.mode != lpm_pkg::M_DEEP && (!LOW_POWER_READY_I || DEBUG_CONNECTED_I)) |=> st_q.mode != lpm_pkg::M_DEEP)
		else $error("deep sleep entered while not allowed");
	a_parked_deepens: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q.mode == lpm_pkg::M_SLEEP && st_q.ds_pend && deep_ok && !(|wake_v) && quiet)
		|=> st_q.mode == lpm_pkg::M_DEEP) else $error("parked deep request did not complete");
	a_deep_controls: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		st_q.mode == lpm_pkg::M_DEEP |-> (!HF_CLK_EN_O && LF_CLK_EN_O && IO_FREEZE_O && RETENTION_EN_O
		&& NONRET_RESET_O && DEEP_REG_EN_O && !ACTIVE_REG_EN_O)) else $error("deep sleep controls wrong");
	a_freeze_key: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q.mode == lpm_pkg::M_ACTIVE && IO_FREEZE_O) |-> unlocked) else $error("freeze without unlock key");
	a_hib_controls: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		st_q.mode == lpm_pkg::M_HIB |-> (!HF_CLK_EN_O && !LF_CLK_EN_O && RETENTION_EN_O && IO_FREEZE_O
		&& !ACTIVE_REG_EN_O && !DEEP_REG_EN_O)) else $error("hibernate controls wrong");
	a_deep_irq_wake: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q.mode == lpm_pkg::M_DEEP && IRQ_ENABLED_I[0] && quiet) |=> (st_q.mode == lpm_pkg::M_ACTIVE
		&& HF_CLK_EN_O && !RETENTION_EN_O && (!IO_FREEZE_O || unlocked))) else $error("deep wake not restored");
	a_debug_wake: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q.mode == lpm_pkg::M_DEEP && DEBUG_WAKE_I && !(|wake_v) && quiet) |=> (st_q.mode == lpm_pkg::M_SLEEP
		&& HF_CLK_EN_O && !RETENTION_EN_O && CORE_CLK_EN_O == 2'h0)) else $error("debug wake wrong");
	a_hib_wake_path: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q.mode == lpm_pkg::M_HIB && wk.wake && quiet) |=> (st_q.mode == lpm_pkg::M_HIB_WAKE && SYS_RESET_O
		&& ACTIVE_REG_EN_O && !MAIN_OSC_EN_O)) else $error("hibernate wake skipped reset");
	a_mode_visible: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(st_q.mode == lpm_pkg::M_SLEEP) |-> (POWER_MODE_O == 3'h3 && !SYS_RESET_O)) else $error("mode output wrong");
endmodule // lpm_ctrl

// ---- verification/core_model.sv ----
// Purpose: behavioural model of the two cores that ask for low-power modes
// Assumes: control bits are levels, wait and handler exit are one-cycle pulses
// Notes: the cores may execute their wait instructions some cycles apart
`timescale 1ns/100ps
module core_model (
	// clock
	input wire logic clk_i,
	// core requests
	output logic [1:0] deep_sel_o,
	output logic [1:0] exit_sleep_o,
	output logic [1:0] wake_pend_o,
	output logic [1:0] wait_o,
	output logic [1:0] isr_exit_o
);
	initial begin
		{deep_sel_o, exit_sleep_o, wake_pend_o, wait_o, isr_exit_o} = 10'h000;
	end

	task automatic setup(input logic [1:0] ds, input logic [1:0] soe, input logic [1:0] wop);
		@(posedge clk_i);
		deep_sel_o <= ds;
		exit_sleep_o <= soe;
		wake_pend_o <= wop;
	endtask

	// wait on all cores
	// a gap models a slow core that reaches its wait later
	task automatic wait_all(input int gap);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			wait_o[i] <= 1'b1;
			@(posedge clk_i);
			wait_o <= 2'h0;
			repeat (gap) @(posedge clk_i);
		end
	endtask

	task automatic isr_exit(input logic [1:0] m);
		@(posedge clk_i);
		isr_exit_o <= m;
		@(posedge clk_i);
		isr_exit_o <= 2'h0;
	endtask
endmodule // core_model

// ---- verification/low_power_mode_controller_test.sv ----
// Purpose: self-checking bench for the low-power mode controller
// Assumes: 100 MHz clock, register bus driven by the tasks below
// Notes: stimulus changes on the rising edge, outputs are sampled on the falling edge
`timescale 1ns/100ps
module low_power_mode_controller_test;
	logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic ext_n = 1'b1, int_rst = 1'b0, lp_rdy = 1'b0, dbg = 1'b0, dbg_wk = 1'b0, alarm = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdata;
	logic [3:0] strb = 4'hf;
	logic [1:0] irq_en = 2'h0, irq_pend = 2'h0, ds, soe, wop, cw, cx, bresp, rresp, cclk;
	logic [3:0] pins = 4'h0;
	logic awr, wrdy, bval, arr, rval, hf, lf, osc, frz, ret, nret, areg, dreg, sysr;
	logic [2:0] mode;
	int err_total = 0, checks_done = 0;
	wire [8:0] pw = {hf, lf, osc, frz, ret, nret, areg, dreg, sysr};

	always #5 clk = ~clk;

	core_model i_core_model (.clk_i(clk), .deep_sel_o(ds), .exit_sleep_o(soe), .wake_pend_o(wop),
		.wait_o(cw), .isr_exit_o(cx));
	lpm_ctrl i_lpm_ctrl (.CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
		.S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(strb), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bval), .S_AXI_BREADY_I(bre),
		.S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
		.S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rval), .S_AXI_RREADY_I(rre),
		.CORE_DEEP_SLEEP_SELECT_I(ds), .CORE_SLEEP_ON_ISR_EXIT_I(soe), .CORE_WAKE_ON_PENDING_I(wop),
		.CORE_WAIT_I(cw), .CORE_ISR_EXIT_I(cx), .IRQ_ENABLED_I(irq_en), .IRQ_PENDING_I(irq_pend),
		.EXT_RESET_N_I(ext_n), .INT_RESET_I(int_rst), .LOW_POWER_READY_I(lp_rdy),
		.DEBUG_CONNECTED_I(dbg), .DEBUG_WAKE_I(dbg_wk), .WAKE_PIN_I(pins), .RTC_ALARM_I(alarm),
		.CORE_CLK_EN_O(cclk), .HF_CLK_EN_O(hf), .LF_CLK_EN_O(lf), .MAIN_OSC_EN_O(osc),
		.IO_FREEZE_O(frz), .RETENTION_EN_O(ret), .NONRET_RESET_O(nret), .ACTIVE_REG_EN_O(areg),
		.DEEP_REG_EN_O(dreg), .SYS_RESET_O(sysr), .POWER_MODE_O(mode));

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	// a mode that never arrives ends the run at once
	task automatic wm(input logic [2:0] e, input int lim);
		for (int n = 0; n < lim; n++) begin
			@(negedge clk);
			if (mode === e)
				break;
		end
		chk(mode, e, "power mode");
		if (mode !== e)
			summarize();
	endtask

	// pending channels kept locally: the bus signals themselves update only after this time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [2:0] ok;
		logic [2:0] pend;
		pend = 3'h7;
		@(posedge clk);
		awa <= a;
		wd <= d;
		strb <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		for (int n = 0; pend != 3'h0; n++) begin
			if (n > 50) begin
				chk(n, 0, "write timed out");
				summarize();
			end
			@(negedge clk);
			ok = {awr & awv, wrdy & wv, bval & bre};
			if (ok[0])
				chk(bresp, lpm_pkg::RESP_OKAY, "write response");
			@(posedge clk);
			pend = pend & ~ok;
			awv <= pend[2];
			wv <= pend[1];
			bre <= pend[0];
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [1:0] ok;
		logic [1:0] pend;
		pend = 2'h3;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		for (int n = 0; pend != 2'h0; n++) begin
			if (n > 50) begin
				chk(n, 0, "read timed out");
				summarize();
			end
			@(negedge clk);
			ok = {arr & arv, rval & rre};
			if (ok[0]) begin
				chk(rdata, e, "read data");
				chk(rresp, er, "read response");
			end
			@(posedge clk);
			pend = pend & ~ok;
			arv <= pend[1];
			rre <= pend[0];
		end
	endtask

	task automatic t_reset;
		@(negedge clk);
		chk(mode, lpm_pkg::M_RESET, "reset mode");
		chk(pw, 9'h1cd, "reset outputs");
		wm(lpm_pkg::M_ACTIVE, 110);
		chk(pw, 9'h1c4, "active outputs");
		$display("test reset done");
	endtask

	task automatic t_sleep;
		i_core_model.setup(2'h0, 2'h1, 2'h1);
		i_core_model.wait_all(3);
		wm(lpm_pkg::M_SLEEP, 4);
		chk(cclk, 2'h0, "core clocks gated");
		@(posedge clk);
		irq_en <= 2'h1;
		wm(lpm_pkg::M_ACTIVE, 3);
		chk(cclk, 2'h1, "core clock after wake");
		@(posedge clk);
		irq_en <= 2'h0;
		i_core_model.isr_exit(2'h1);
		wm(lpm_pkg::M_SLEEP, 4);
		@(posedge clk);
		irq_pend <= 2'h1;
		wm(lpm_pkg::M_ACTIVE, 3);
		@(posedge clk);
		irq_pend <= 2'h0;
		i_core_model.isr_exit(2'h1);
		wm(lpm_pkg::M_SLEEP, 4);
		@(posedge clk);
		alarm <= 1'b1;
		wm(lpm_pkg::M_ACTIVE, 3);
		@(posedge clk);
		alarm <= 1'b0;
		irq_en <= 2'h2;
		@(posedge clk);
		irq_en <= 2'h0;
		i_core_model.setup(2'h0, 2'h0, 2'h0);
		@(negedge clk);
		chk(cclk, 2'h3, "both cores running");
		$display("test sleep done");
	endtask

	task automatic t_deep;
		rd(lpm_pkg::PWR_CTRL_ADDR, 32'h2, lpm_pkg::RESP_OKAY);
		i_core_model.setup(2'h3, 2'h0, 2'h0);
		i_core_model.wait_all(0);
		wm(lpm_pkg::M_SLEEP, 4);
		@(posedge clk);
		dbg <= 1'b1;
		lp_rdy <= 1'b1;
		repeat (6) @(negedge clk);
		chk(mode, lpm_pkg::M_SLEEP, "held by debugger");
		rd(lpm_pkg::PWR_CTRL_ADDR, 32'h23, lpm_pkg::RESP_OKAY);
		@(posedge clk);
		dbg <= 1'b0;
		wm(lpm_pkg::M_DEEP, 3);
		chk(pw, 9'h0ba, "deep outputs");
		@(posedge clk);
		dbg <= 1'b1;
		dbg_wk <= 1'b1;
		@(posedge clk);
		dbg_wk <= 1'b0;
		wm(lpm_pkg::M_SLEEP, 3);
		chk(pw, 9'h1c4, "debug wake outputs");
		chk(cclk, 2'h0, "cores still asleep");
		@(posedge clk);
		dbg <= 1'b0;
		wm(lpm_pkg::M_DEEP, 3);
		@(posedge clk);
		irq_en <= 2'h3;
		wm(lpm_pkg::M_ACTIVE, 3);
		chk(pw, 9'h1c4, "restored outputs");
		@(posedge clk);
		irq_en <= 2'h0;
		i_core_model.setup(2'h0, 2'h0, 2'h0);
		$display("test deep sleep done");
	endtask

	// interrupts stay off from the first control write until the cores wait
	task automatic t_hib;
		wr(lpm_pkg::HIB_SCRATCH_ADDR, 32'ha5c3_0f1e, 4'hf);
		wr(lpm_pkg::HIB_SCRATCH_ADDR, 32'h0000_7700, 4'h2);
		rd(lpm_pkg::HIB_SCRATCH_ADDR, 32'ha5c3_771e, lpm_pkg::RESP_OKAY);
		wr(lpm_pkg::HIB_CTRL_ADDR, 32'h0002_005a, 4'hf);
		@(negedge clk);
		chk(frz, 1'b0, "freeze without key");
		wr(lpm_pkg::HIB_CTRL_ADDR, 32'h8112_3a5a, 4'hf);
		rd(lpm_pkg::HIB_CTRL_ADDR, 32'h8112_3a5a, lpm_pkg::RESP_OKAY);
		rd(8'h0c, 32'h0, lpm_pkg::RESP_SLVERR);
		chk(frz, 1'b1, "freeze with key");
		i_core_model.wait_all(1);
		wm(lpm_pkg::M_HIB, 4);
		chk(pw, 9'h038, "hibernate outputs");
		@(posedge clk);
		pins <= 4'h2;
		repeat (6) @(negedge clk);
		chk(mode, lpm_pkg::M_HIB, "masked or wrong level pin");
		@(posedge clk);
		pins <= 4'h3;
		wm(lpm_pkg::M_HIB_WAKE, 4);
		@(posedge clk);
		pins <= 4'h0;
		wm(lpm_pkg::M_RESET, 205);
		chk(sysr, 1'b1, "wake reset");
		wm(lpm_pkg::M_ACTIVE, 105);
		rd(lpm_pkg::HIB_SCRATCH_ADDR, 32'ha5c3_771e, lpm_pkg::RESP_OKAY);
		rd(lpm_pkg::HIB_CTRL_ADDR, 32'h0112_3a5a, lpm_pkg::RESP_OKAY);
		$display("test hibernate done");
	endtask

	task automatic t_external_reset_pin;
		i_core_model.wait_all(0);
		wm(lpm_pkg::M_SLEEP, 4);
		@(posedge clk);
		ext_n <= 1'b0;
		wm(lpm_pkg::M_RESET, 2);
		chk(sysr, 1'b1, "external reset");
		@(posedge clk);
		ext_n <= 1'b1;
		wm(lpm_pkg::M_ACTIVE, 105);
		chk(cclk, 2'h3, "cores run after reset");
		@(posedge clk);
		int_rst <= 1'b1;
		wm(lpm_pkg::M_RESET, 2);
		@(posedge clk);
		int_rst <= 1'b0;
		wm(lpm_pkg::M_ACTIVE, 105);
		$display("test resets done");
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_sleep();
		t_deep();
		t_hib();
		t_external_reset_pin();
		summarize();
	end
endmodule // low_power_mode_controller_test
